// ===== tws_engine.sv
`timescale 1ns/1ps
module tws_engine
   import tws_pkg::*;
(
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   // bus pins, open drain: oe low means pulling the line low
   input  wire logic                 scl_i,
   output logic                      scl_o,
   output logic                      scl_oe_n_o,
   input  wire logic                 sda_i,
   output logic                      sda_o,
   output logic                      sda_oe_n_o,
   // configuration
   input  wire logic [TWS_BRG_W-1:0] baud_div_i,
   input  wire logic                 tick_i,
   input  wire logic                 enable_i,
   input  wire logic                 condition_generator_select_i,
   input  wire logic                 start_request_i,
   input  wire logic                 restart_request_i,
   input  wire logic                 stop_request_i,
   input  wire logic                 arbitration_update_select_i,
   input  wire logic                 arb_clear_i,
   input  wire logic                 sda_stop_on_loss_i,
   input  wire logic                 clock_sync_enable_i,
   input  wire logic                 ninth_bit_wait_set_i,
   input  wire logic                 ninth_bit_wait_clear_i,
   input  wire logic                 clock_release_on_stop_i,
   input  wire logic                 clock_force_low_i,
   input  wire logic                 clock_hold_after_ninth_i,
   input  wire logic                 clock_phase_delay_i,
   input  wire logic [2:0]           sda_delay_select_i,
   input  wire logic                 sda_output_disable_i,
   input  wire logic                 two_wire_interrupt_select_i,
   input  wire logic                 ack_output_enable_i,
   input  wire logic                 ack_bit_value_i,
   input  wire logic                 start_reset_enable_i,
   input  wire logic [TWS_DAT_W-1:0] tx_data_i,
   input  wire logic                 tx_load_i,
   // status and events
   output logic                      bus_busy_flag_o,
   output logic                      cond_event_o,
   output logic                      arbitration_lost_flag_o,
   output logic                      ninth_bit_wait_hold_o,
   output logic [TWS_RX_W-1:0]       rx_buffer_o,
   output logic                      rx_done_o,
   output logic                      ack_req_o,
   output logic                      nack_req_o,
   output logic                      dma_req_o,
   output logic                      gen_busy_o
);
   // ===========================================================
   // pin history and edges
   logic scl_q, sda_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end
   wire start_det = scl_i && scl_q && sda_q && !sda_i;
   wire stop_det  = scl_i && scl_q && !sda_q && sda_i;
   wire pin_fall  = scl_q && !scl_i;

   // ===========================================================
   // internal clock divider
   logic                 int_scl;
   logic [TWS_BRG_W-1:0] brg_cnt;
   logic [3:0]           bit_cnt;
   logic                 shifting;
   wire sync_on   = clock_sync_enable_i && shifting;
   wire sync_fall = sync_on && int_scl && pin_fall;
   wire stalled   = int_scl && !scl_i;
   wire xfer_clk  = int_scl && scl_i;
   logic xfer_q;
   wire  xfer_rise = xfer_clk && !xfer_q;
   wire  xfer_fall = !xfer_clk && xfer_q;
   wire  brg_zero  = (brg_cnt == TWS_BRG_RST);

   // ===========================================================
   // holds on SCL
   logic wait_hold, hold9, clk_release;
   // wait hold must outlive the byte, so it is latched at the ninth fall
   logic hold_w;
   wire ninth_fall = xfer_fall && (bit_cnt == TWS_NINTH);
   wire drive_scl_low = clock_force_low_i
                     || hold_w
                     || hold9
                     || (shifting && !int_scl);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         int_scl <= 1'b1;
         brg_cnt <= TWS_BRG_RST;
         xfer_q  <= 1'b1;
      end else begin
         xfer_q <= xfer_clk;
         if (sync_fall) begin
            int_scl <= 1'b0;
            brg_cnt <= baud_div_i;
         end else if (!shifting || (stalled && sync_on)) begin
            brg_cnt <= brg_cnt;
         end else if (tick_i) begin
            if (brg_zero) begin
               brg_cnt <= baud_div_i;
               int_scl <= !int_scl;
            end else begin
               brg_cnt <= brg_cnt - 8'h01;
            end
         end
         if (!shifting && !sync_fall) int_scl <= 1'b1;
      end
   end

   // ===========================================================
   // bit engine
   logic [TWS_DAT_W-1:0] tx_sh;
   logic [TWS_DAT_W-1:0] rx_sh;
   logic                 tx_bit, mism, arb;
   // slot after the eighth fall is the acknowledge slot: line released
   wire cur_tx   = (bit_cnt == TWS_EIGHTH) ? 1'b1 : tx_sh[TWS_DAT_W-1];
   wire mismatch = xfer_rise && tx_bit && !sda_i
                   && (bit_cnt != TWS_NINTH);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_sh     <= 8'h00;
         rx_sh     <= 8'h00;
         bit_cnt   <= TWS_BIT_ZERO;
         shifting  <= 1'b0;
         tx_bit    <= 1'b1;
         mism      <= 1'b0;
         arb       <= 1'b0;
         wait_hold <= 1'b0;
         hold9     <= 1'b0;
         hold_w    <= 1'b0;
         rx_buffer_o <= TWS_RX_RST;
         rx_done_o <= 1'b0;
         ack_req_o <= 1'b0;
         nack_req_o <= 1'b0;
         dma_req_o <= 1'b0;
      end else begin
         rx_done_o  <= 1'b0;
         ack_req_o  <= 1'b0;
         nack_req_o <= 1'b0;
         dma_req_o  <= 1'b0;
         if (ninth_bit_wait_set_i) wait_hold <= 1'b1;
         else if (ninth_bit_wait_clear_i) wait_hold <= 1'b0;
         if (!clock_hold_after_ninth_i) hold9 <= 1'b0;
         if (!wait_hold) hold_w <= 1'b0;
         else if (ninth_fall) hold_w <= 1'b1;
         if (start_det && start_reset_enable_i) begin
            tx_sh     <= tx_data_i;
            rx_sh     <= 8'h00;
            bit_cnt   <= TWS_BIT_ZERO;
            shifting  <= 1'b1;
            wait_hold <= 1'b1;
         end else if (tx_load_i && enable_i && !shifting) begin
            tx_sh    <= tx_data_i;
            bit_cnt  <= TWS_BIT_ZERO;
            shifting <= 1'b1;
         end else if (shifting) begin
            if (xfer_fall) begin
               tx_bit <= cur_tx;
               if (bit_cnt == TWS_NINTH) begin
                  shifting <= 1'b0;
                  bit_cnt  <= TWS_BIT_ZERO;
                  if (arbitration_update_select_i && mism) arb <= 1'b1;
                  if (clock_phase_delay_i && clock_hold_after_ninth_i)
                     hold9 <= 1'b1;
                  mism <= 1'b0;
               end else begin
                  bit_cnt <= bit_cnt + 4'h1;
                  tx_sh   <= {tx_sh[TWS_DAT_W-2:0], 1'b0};
               end
            end
            if (xfer_rise) begin
               if (!arbitration_update_select_i) begin
                  if (bit_cnt != TWS_NINTH) arb <= mismatch;
               end else if (mismatch) mism <= 1'b1;
               if (bit_cnt == TWS_NINTH) begin
                  ack_req_o  <= !two_wire_interrupt_select_i && !sda_i;
                  nack_req_o <= !two_wire_interrupt_select_i && sda_i;
                  dma_req_o  <= !two_wire_interrupt_select_i && !sda_i;
                  rx_done_o  <= 1'b1;
                  if (two_wire_interrupt_select_i)
                     rx_buffer_o <= {rx_sh[0], 1'b0, rx_sh[7:1]};
                  else
                     rx_buffer_o <= {sda_i, rx_sh};
               end else begin
                  rx_sh <= {rx_sh[TWS_DAT_W-2:0], sda_i};
               end
            end
         end
         if (arb_clear_i && !(xfer_rise && mismatch)) begin
            if (arbitration_update_select_i) arb <= 1'b0;
         end
      end
   end

   // ===========================================================
   // condition generator
   tws_gen_e gen_st;
   logic     gen_sda, gen_scl, is_stop, gen_done;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gen_st   <= TWS_GEN_IDLE;
         gen_sda  <= 1'b1;
         gen_scl  <= 1'b1;
         is_stop  <= 1'b0;
         gen_done <= 1'b0;
      end else begin
         gen_done <= 1'b0;
         case (gen_st)
            TWS_GEN_IDLE: begin
               if (condition_generator_select_i &&
                   (start_request_i || restart_request_i || stop_request_i)) begin
                  is_stop <= stop_request_i;
                  gen_sda <= !stop_request_i;
                  gen_scl <= !restart_request_i && !stop_request_i;
                  gen_st  <= TWS_GEN_SETUP;
               end
            end
            TWS_GEN_SETUP: if (tick_i) begin
               gen_scl <= 1'b1;
               gen_st  <= TWS_GEN_SCL_HI;
            end
            TWS_GEN_SCL_HI: if (tick_i && scl_i) begin
               gen_sda <= is_stop;
               gen_st  <= TWS_GEN_SDA_EDGE;
            end
            TWS_GEN_SDA_EDGE: if (tick_i) begin
               gen_scl  <= is_stop;
               gen_st   <= TWS_GEN_DONE;
            end
            TWS_GEN_DONE: begin
               gen_done <= 1'b1;
               gen_sda  <= 1'b1;
               gen_scl  <= 1'b1;
               if (!condition_generator_select_i) gen_st <= TWS_GEN_IDLE;
            end
            default: gen_st <= TWS_GEN_IDLE;
         endcase
      end
   end
   wire gen_active = (gen_st != TWS_GEN_IDLE);

   // ===========================================================
   // SDA path
   wire sda_raw   = (!condition_generator_select_i && ack_output_enable_i
                     && bit_cnt == TWS_NINTH) ? ack_bit_value_i : tx_bit;
   logic sda_dly;
   tws_sda_delay u_delay (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .tick_i      (tick_i),
      .delay_sel_i (sda_delay_select_i),
      .bit_i       (sda_raw),
      .bit_o       (sda_dly)
   );
   wire sda_release = sda_output_disable_i
                   || (sda_stop_on_loss_i && arb);
   wire sda_low = gen_active ? !gen_sda : (!sda_release && !sda_dly);
   wire scl_low = gen_active ? !gen_scl : (drive_scl_low && !clk_release);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_release <= 1'b0;
         bus_busy_flag_o <= 1'b0;
         cond_event_o <= 1'b0;
         sda_oe_n_o <= 1'b1;
         scl_oe_n_o <= 1'b1;
         sda_o <= 1'b0;
         scl_o <= 1'b0;
         arbitration_lost_flag_o <= 1'b0;
         ninth_bit_wait_hold_o <= 1'b0;
         gen_busy_o <= 1'b0;
      end else begin
         if (stop_det && clock_release_on_stop_i) clk_release <= 1'b1;
         else if (start_det || !clock_release_on_stop_i) clk_release <= 1'b0;
         if (start_det) bus_busy_flag_o <= 1'b1;
         else if (stop_det) bus_busy_flag_o <= 1'b0;
         cond_event_o <= condition_generator_select_i ? gen_done
                                                       : (start_det || stop_det);
         sda_oe_n_o <= !sda_low;
         scl_oe_n_o <= !scl_low;
         sda_o <= 1'b0;
         scl_o <= 1'b0;
         arbitration_lost_flag_o <= arb;
         ninth_bit_wait_hold_o <= wait_hold;
         gen_busy_o <= gen_active;
      end
   end

   // ===========================================================
   // checks
   property p_busy_start;
      @(posedge clk_i) disable iff (!rst_n_i)
      start_det |=> bus_busy_flag_o;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy not set");
   property p_busy_stop;
      @(posedge clk_i) disable iff (!rst_n_i)
      stop_det && !start_det |=> !bus_busy_flag_o;
   endproperty
   a_busy_stop: assert property (p_busy_stop) else $error("busy not cleared");
   property p_disable;
      @(posedge clk_i) disable iff (!rst_n_i)
      sda_output_disable_i && !gen_active |=> sda_oe_n_o;
   endproperty
   a_disable: assert property (p_disable) else $error("sda driven while off");
   property p_force;
      @(posedge clk_i) disable iff (!rst_n_i)
      clock_force_low_i && !gen_active && !clk_release |=> !scl_oe_n_o;
   endproperty
   a_force: assert property (p_force) else $error("scl not forced low");
   property p_od;
      @(posedge clk_i) disable iff (!rst_n_i)
      !sda_o && !scl_o;
   endproperty
   a_od: assert property (p_od) else $error("line driven high");
   property p_loss;
      @(posedge clk_i) disable iff (!rst_n_i)
      sda_stop_on_loss_i && arb && !gen_active |=> sda_oe_n_o;
   endproperty
   a_loss: assert property (p_loss) else $error("sda kept after loss");
   property p_start_rst;
      @(posedge clk_i) disable iff (!rst_n_i)
      start_det && start_reset_enable_i |=> wait_hold && shifting && bit_cnt == TWS_BIT_ZERO;
   endproperty
   a_start_rst: assert property (p_start_rst) else $error("start reset missed");
   property p_bitmode;
      @(posedge clk_i) disable iff (!rst_n_i)
      shifting && xfer_rise && !arbitration_update_select_i && !start_det
         && bit_cnt != TWS_NINTH
         |=> arb == $past(mismatch);
   endproperty
   a_bitmode: assert property (p_bitmode) else $error("per-bit flag wrong");
endmodule : tws_engine

// ===== tws_pkg.sv
// How it works
// - start or stop flagged from SDA edge under high SCL
// - generator drives start, restart, stop on request
// - condition event on detection or generation end
// - compare sent bit with SDA at SCL rise
// - per-bit mode: loss flag follows each compare
// - per-byte mode: loss set at ninth fall
// - loss releases SDA when stop-on-loss enabled
// - SCL fall forces internal clock low, reloads divider
// - divider pauses while pin low; clock is AND
// - sync spans first bit to ninth fall
// - wait hold drives SCL low at ninth fall
// - release-on-stop floats SCL after stop detected
// - force-low drives SCL low until cleared
// - delayed clock hold-after-ninth keeps SCL low
// - transmit MSB first, ninth slot ACK/NACK
// - SDA delay zero or two to eight ticks
// - SDA disable holds SDA released
// - receive layout depends on interrupt select
// - ACK output drives programmed ACK bit while generator select low
// - ninth rise SDA gives ACK or NACK request while interrupt select low
// - start resets shifters, reloads, sets wait hold
package tws_pkg;
   // ===========================================================
   // widths and codes
   localparam int          TWS_BRG_W     = 8;
   localparam int          TWS_DAT_W     = 8;
   localparam int          TWS_RX_W      = 9;
   localparam logic [3:0]  TWS_NINTH     = 4'h9;
   localparam logic [3:0]  TWS_EIGHTH    = 4'h8;
   localparam logic [3:0]  TWS_BIT_ZERO  = 4'h0;
   localparam logic [2:0]  TWS_DLY_NONE  = 3'h0;
   localparam logic [3:0]  TWS_DLY_BASE  = 4'h1;
   localparam logic [8:0]  TWS_RX_RST    = 9'h000;
   localparam logic [7:0]  TWS_BRG_RST   = 8'h00;

   typedef enum logic [2:0] {
      TWS_GEN_IDLE,
      TWS_GEN_SETUP,
      TWS_GEN_SCL_HI,
      TWS_GEN_SDA_EDGE,
      TWS_GEN_DONE
   } tws_gen_e;
endpackage : tws_pkg

// ===== tws_sda_delay.sv
`timescale 1ns/1ps
module tws_sda_delay
   import tws_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // control
   input  wire logic       tick_i,
   input  wire logic [2:0] delay_sel_i,
   // data
   input  wire logic       bit_i,
   output logic            bit_o
);
   // ===========================================================
   // tick-counted delay line
   logic [3:0] cnt;
   logic       pend;
   logic       held;
   wire  [3:0] target = {1'b0, delay_sel_i} + TWS_DLY_BASE;
   wire        no_dly = (delay_sel_i == TWS_DLY_NONE);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt   <= TWS_BIT_ZERO;
         pend  <= 1'b0;
         held  <= 1'b1;
         bit_o <= 1'b1;
      end else begin
         if (no_dly) begin
            bit_o <= bit_i;
            pend  <= 1'b0;
         end else if (bit_i != held) begin
            held <= bit_i;
            pend <= 1'b1;
            // first tick already counts, so a setting of n waits n+1 ticks
            cnt  <= TWS_DLY_BASE;
         end else if (pend && tick_i) begin
            if (cnt == target) begin
               bit_o <= held;
               pend  <= 1'b0;
            end else begin
               cnt <= cnt + TWS_DLY_BASE;
            end
         end
      end
   end
endmodule : tws_sda_delay

// ===== tws_bus_partner.sv
`timescale 1ns/1ps
module tws_bus_partner (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // device open-drain enables, low pulls the line
   input  wire logic       dev_scl_oe_n_i,
   input  wire logic       dev_sda_oe_n_i,
   // bench commands
   input  wire logic       ack_en_i,
   input  wire logic       pull_sda_i,
   input  wire logic       stretch_i,
   input  wire logic       tb_sda_low_i,
   // resolved lines and capture
   output logic            scl_o,
   output logic            sda_o,
   output logic [7:0]      rx_byte_o
);
   // ==========================================================
   // wired-and lines with pull-ups
   logic [3:0] nrise;
   logic [2:0] hold;
   logic       scl_q;
   logic       sda_q;
   logic       ack_on;
   assign scl_o = dev_scl_oe_n_i & (hold == 3'h0);
   assign sda_o = dev_sda_oe_n_i & ~tb_sda_low_i & ~pull_sda_i & ~(ack_on & ack_en_i);
   // ==========================================================
   // bit counting, acknowledge slot and clock stretching
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {nrise, hold, scl_q, sda_q, ack_on, rx_byte_o} <= '0;
      end else begin
         scl_q <= scl_o;
         sda_q <= sda_o;
         // a start or stop restarts the bit count
         if (scl_q & scl_o & (sda_q != sda_o)) begin
            nrise  <= 4'h0;
            ack_on <= 1'b0;
         end else if (~scl_q & scl_o) begin
            // the return to idle high after a byte is not a data rise
            if (nrise == 4'hF) nrise <= 4'h0;
            else begin
               nrise <= nrise + 4'h1;
               if (nrise < 4'h8) rx_byte_o <= {rx_byte_o[6:0], sda_o};
            end
         end else if (scl_q & ~scl_o) begin
            ack_on <= (nrise == 4'h8);
            if (nrise == 4'h9) nrise <= 4'hF;
         end
         // slow far side holds the clock low after each fall
         if (scl_q & ~scl_o & stretch_i) hold <= 3'h5;
         else if (hold != 3'h0) hold <= hold - 3'h1;
      end
   end
endmodule : tws_bus_partner

// ===== tws_tb.sv
`timescale 1ns/1ps
module testbench;
   import tws_pkg::*;
   // ==========================================================
   // signals
   logic        clk_i, rst_n_i, tick, en, gsel, sreq, rreq, preq, abc, aclr, sol, clock_sync_enable;
   logic        wset, wclr, ros, flo, han, cph, sdis, isel, acke, ackv, start_reset_enable, tld;
   logic        p_ack, p_pull, p_str, t_sda, scl, sda, drove;
   logic        scl_oe_n, sda_oe_n, busy, cev, arb, whold, rxd, ackr, nackr, dma, gbusy;
   logic [2:0]  dsel;
   logic [7:0]  bdiv, txd, p_rx;
   logic [8:0]  rxb;
   logic [23:0] exp_q[$];
   int          failures, comparisons;

   tws_engine DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .scl_o(),
      .scl_oe_n_o(scl_oe_n), .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n),
      .baud_div_i(bdiv), .tick_i(tick), .enable_i(en), .condition_generator_select_i(gsel),
      .start_request_i(sreq), .restart_request_i(rreq), .stop_request_i(preq),
      .arbitration_update_select_i(abc), .arb_clear_i(aclr), .sda_stop_on_loss_i(sol),
      .clock_sync_enable_i(clock_sync_enable), .ninth_bit_wait_set_i(wset), .ninth_bit_wait_clear_i(wclr),
      .clock_release_on_stop_i(ros), .clock_force_low_i(flo), .clock_hold_after_ninth_i(han),
      .clock_phase_delay_i(cph), .sda_delay_select_i(dsel), .sda_output_disable_i(sdis),
      .two_wire_interrupt_select_i(isel), .ack_output_enable_i(acke), .ack_bit_value_i(ackv),
      .start_reset_enable_i(start_reset_enable), .tx_data_i(txd), .tx_load_i(tld), .bus_busy_flag_o(busy),
      .cond_event_o(cev), .arbitration_lost_flag_o(arb), .ninth_bit_wait_hold_o(whold),
      .rx_buffer_o(rxb), .rx_done_o(rxd), .ack_req_o(ackr), .nack_req_o(nackr),
      .dma_req_o(dma), .gen_busy_o(gbusy));

   tws_bus_partner far_side (.clk_i(clk_i), .rst_n_i(rst_n_i), .dev_scl_oe_n_i(scl_oe_n),
      .dev_sda_oe_n_i(sda_oe_n), .ack_en_i(p_ack), .pull_sda_i(p_pull), .stretch_i(p_str),
      .tb_sda_low_i(t_sda), .scl_o(scl), .sda_o(sda), .rx_byte_o(p_rx));

   // ==========================================================
   // checking and closing
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   // result watcher: oldest note against each finished byte
   always @(posedge clk_i) begin : watch
      logic [23:0] e;
      if (rxd === 1'b1) begin
         if (exp_q.size() == 0) check(0, 1, "byte not expected");
         else begin
            e = exp_q.pop_front();
            check({dma, ackr, nackr, rxb} & e[23:12], e[11:0], "received byte");
         end
      end
   end

   always @(posedge clk_i) if (sda_oe_n === 1'b0) drove <= 1'b1;
   always @(posedge clk_i) tick <= ~tick;
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      repeat (60000) @(posedge clk_i);
      failures++;
      give_verdict();
   end

   // ==========================================================
   // stimulus tasks
   task automatic wait_ev(input string what);
      int n;
      for (n = 0; n < 300; n++) begin
         @(posedge clk_i);
         #1;
         if (cev === 1'b1) break;
      end
      if (n == 300) check(0, 1, what);
   endtask : wait_ev

   // w is the byte expected on the wire, a a low level in the ninth slot
   task automatic send_byte(input logic [7:0] d, input logic [7:0] w, input logic pa,
                            input logic a);
      int n;
      @(posedge clk_i);
      txd   <= d;
      tld   <= 1'b1;
      p_ack <= pa;
      drove <= 1'b0;
      if (isel) exp_q.push_back({12'h17F, 3'h0, w[0], 1'b0, w[7:1]});
      else exp_q.push_back({12'hEFF, a, a, ~a, 1'b0, w});
      @(posedge clk_i) tld <= 1'b0;
      for (n = 0; n < 3000 && rxd !== 1'b1; n++) @(posedge clk_i);
      if (n == 3000) check(0, 1, "byte timeout");
      repeat (60) @(posedge clk_i);
      check(p_rx, w, "bits on wire");
   endtask : send_byte

   // ==========================================================
   // tests
   initial begin : main
      int i;
      {rst_n_i, tick, en, gsel, sreq, rreq, preq, abc, aclr, sol, clock_sync_enable, wset, wclr} = '0;
      {flo, han, cph, sdis, isel, acke, ackv, start_reset_enable, tld, p_ack, p_pull, p_str, t_sda} = '0;
      {drove, dsel, txd, failures, comparisons} = '0;
      ros  = 1'b1;
      en   = 1'b1;
      bdiv = 8'h0F;
      void'($urandom(81329));
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      #1 check({scl_oe_n, sda_oe_n, busy, arb}, 4'hC, "reset state");
      @(posedge clk_i) t_sda <= 1'b1;
      wait_ev("start not seen");
      check(busy, 1, "busy after start");
      @(posedge clk_i) t_sda <= 1'b0;
      wait_ev("stop not seen");
      check(busy, 0, "busy after stop");
      $display("test detect done");
      for (i = 0; i < 3; i++) begin
         @(posedge clk_i) {sreq, rreq, preq} <= 3'b100 >> i;
         @(posedge clk_i) gsel <= 1'b1;
         wait_ev("condition not generated");
         check(busy, i < 2, "busy after generation");
         @(posedge clk_i) {gsel, sreq, rreq, preq} <= '0;
      end
      repeat (4) @(posedge clk_i);
      check(scl_oe_n, 1, "clock released after stop");
      $display("test generate done");
      @(posedge clk_i) {clock_sync_enable, ros} <= 2'b10;
      for (i = 0; i < 8; i++) begin
         @(posedge clk_i);
         dsel  <= i[2:0];
         isel  <= i[2];
         p_str <= i[1];
         txd   <= 8'($urandom);
         @(posedge clk_i);
         send_byte(txd, txd, i[0], i[0]);
      end
      @(posedge clk_i) {isel, p_str, acke} <= 3'b001;
      for (i = 0; i < 2; i++) begin
         @(posedge clk_i) ackv <= i[0];
         send_byte(8'hFF, 8'hFF, 1'b0, ~i[0]);
      end
      @(posedge clk_i) {acke, sdis} <= 2'b01;
      send_byte(8'h00, 8'hFF, 1'b0, 1'b0);
      check(drove, 0, "data line driven while disabled");
      @(posedge clk_i) {sdis, sol} <= 2'b01;
      $display("test bytes done");
      for (i = 0; i < 2; i++) begin
         @(posedge clk_i) {abc, p_pull} <= {i[0], 1'b1};
         send_byte(8'hFF, 8'h00, 1'b0, 1'b1);
         check({arb, sda_oe_n}, 2'b11, "lost and released");
         @(posedge clk_i) {p_pull, aclr} <= {1'b0, i[0]};
         @(posedge clk_i) aclr <= 1'b0;
         if (i == 0) send_byte(8'hFF, 8'hFF, 1'b1, 1'b1);
         @(posedge clk_i);
         #1 check(arb, 0, "loss flag cleared");
      end
      $display("test arbitration done");
      @(posedge clk_i) wset <= 1'b1;
      @(posedge clk_i) wset <= 1'b0;
      send_byte(8'h3C, 8'h3C, 1'b1, 1'b1);
      check({scl_oe_n, whold}, 2'b01, "wait hold");
      @(posedge clk_i) wclr <= 1'b1;
      @(posedge clk_i) {wclr, flo} <= 2'b01;
      repeat (4) @(posedge clk_i);
      check(scl_oe_n, 0, "forced low");
      @(posedge clk_i) flo <= 1'b0;
      repeat (4) @(posedge clk_i);
      check({scl_oe_n, whold}, 2'b10, "clock released");
      $display("test clock hold done");
      give_verdict();
   end
endmodule : testbench
